// [logic/tws_pkg.sv]
// Constants, state codes and timing for the two-wire serial slave port
package tws_pkg;
    // ****************************************************************
    // Address and byte layout
    // ****************************************************************
    localparam logic [2:0] TWS_ADDR_HI = 3'h4;        // Fixed upper address bits 1,0,0
    localparam logic [6:0] TWS_GCALL_ADDR = 7'h00;    // General call address
    localparam logic [3:0] TWS_BYTE_BITS = 4'h8;      // Bits per byte
    localparam logic [3:0] TWS_LAST_BIT = 4'h7;       // Index of the last shift
    localparam int TWS_CFG_BYTES = 4;                 // Stored configuration bytes
    localparam logic [1:0] TWS_PTR_W_ZERO = 2'h0;     // Reset value of the write pointer
    localparam logic [7:0] TWS_CFG_RESET = 8'h00;     // Reset value of each config byte
    localparam logic [7:0] TWS_RD_FILL = 8'hff;       // Sent after the two read bytes
    localparam logic [3:0] TWS_STAT_PAD = 4'h0;       // Upper bits of the status byte
    localparam logic TWS_DIR_READ = 1'b1;             // Direction bit value for a read

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int TWS_GLITCH_NS = 50;                // Longest spike to suppress
    localparam int TWS_LINK_PERIOD_NS = 48;           // Link clock period
    // Samples past the first change that must agree before the level moves
    localparam logic [1:0] TWS_FILT_CNT = 2'(TWS_GLITCH_NS / TWS_LINK_PERIOD_NS + 1);

    // ****************************************************************
    // Link state machine, one-hot
    // ****************************************************************
    typedef enum logic [6:0] {
        TWS_ST_IDLE = 7'h01,   // Waiting for a start
        TWS_ST_ADDR = 7'h02,   // Shifting in the address byte
        TWS_ST_AACK = 7'h04,   // Acknowledging the address
        TWS_ST_WRX = 7'h08,    // Shifting in a written byte
        TWS_ST_WACK = 7'h10,   // Acknowledging a written byte
        TWS_ST_RTX = 7'h20,    // Shifting out a read byte
        TWS_ST_RACK = 7'h40    // Master acknowledge slot
    } tws_state_t;
endpackage

// [logic/tws_glitch_filt.sv]
// Pin synchroniser and spike filter for one bus line
module tws_glitch_filt
    import tws_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic pin,
    output logic filt
);
    // ****************************************************************
    // Synchroniser and filter state
    // ****************************************************************
    logic s1_r;            // First synchroniser stage
    logic s2_r;            // Second synchroniser stage
    logic filt_r;          // Accepted line level
    logic filt_nxt;
    logic [1:0] cnt_r;     // Samples seen at the new level
    logic [1:0] cnt_nxt;

    assign filt = filt_r;

    // Two stages; only the second stage feeds any logic
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
        end
    end

    // R2: spike rejection
    // A new level must persist over more than the spike width before it is taken
    always_comb begin
        filt_nxt = filt_r;
        cnt_nxt = 2'h0;
        if (s2_r != filt_r) begin
            if (cnt_r == TWS_FILT_CNT) begin
                filt_nxt = s2_r;
            end else begin
                cnt_nxt = cnt_r + 2'h1;
            end
        end
    end

    // Register the filter; lines idle high
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            filt_r <= 1'b1;
            cnt_r <= 2'h0;
        end else begin
            filt_r <= filt_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // R2: level moves only after a full count
    glitch_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // R2
        $changed(filt_r) |-> $past(cnt_r) == TWS_FILT_CNT && $past(s2_r, 3) == filt_r)
        else $error("filtered level moved on a short pulse");
endmodule

// [logic/tws_slave.sv]
// Two-wire serial slave port: link state machine and system-side hand-off
// Summary of operation
// R1: Idle bus: nobody pulls lines low
// R2: Ignore clock and data spikes up to 50 ns
// R3: Data falls with clock high: start, restart
// R4: Data rises with clock high: stop, end
// R5: Master opens with start, closes with stop
// R6: Only master drives clock; never stretched
// R7: Receiver samples data on clock rise
// R8: Data changes only while clock low
// R9: Bytes are eight bits, MSB first
// R10: Master sends at most four payload bytes
// R11: Receiver drives the acknowledge bit
// R12: Address is 100, offset strap, frequency straps
// R13: General call address zero also accepted
// R14: Full write: start, five bytes, stop
// R15: Acknowledge received byte by pulling data low
// R16: First byte: address, then direction bit
// R17: Written payload bytes stored as configuration
// R18: Master ends a write with stop
// R19: Read: device drives, master samples rises
// R20: Master acknowledges each non-final read byte
// R21: No acknowledge: stop sending, release data
// R22: Read returns status byte, then amplitude
// R23: First payload byte's low bits select target
// R24: Data pin only pulled low, open drain
module tws_slave
    import tws_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic offs_strap,
    input wire logic [2:0] frequency_strap_pins,
    input wire logic [3:0] status_flags,
    input wire logic [7:0] ampl_value,
    output logic [7:0] cfg_byte0,
    output logic [7:0] cfg_byte1,
    output logic [7:0] cfg_byte2,
    output logic [7:0] cfg_byte3,
    output logic cfg_update
);
    // ****************************************************************
    // Link-domain reset and pin conditioning
    // ****************************************************************
    logic lrst_s1_r;             // Reset synchroniser, first stage
    logic lrst_s2_r;             // Link-domain reset, active low
    logic [3:0] strap_s1_r;      // Strap synchroniser, first stage
    logic [3:0] strap_s2_r;      // Strap levels, offset then frequency
    logic scl_f;                 // Filtered clock line
    logic sda_f;                 // Filtered data line
    logic scl_d_r;               // Filtered clock, one sample back
    logic sda_d_r;               // Filtered data, one sample back

    // Reset release is brought into the link clock before use
    always_ff @(posedge link_clk) begin
        lrst_s1_r <= rst_n;
        lrst_s2_r <= lrst_s1_r;
    end

    // Straps are static, but still come from pins
    always_ff @(posedge link_clk) begin
        if (!lrst_s2_r) begin
            strap_s1_r <= 4'h0;
            strap_s2_r <= 4'h0;
        end else begin
            strap_s1_r <= {offs_strap, frequency_strap_pins};
            strap_s2_r <= strap_s1_r;
        end
    end

    // R2: both lines pass the spike filter
    tws_glitch_filt u_scl_filt (
        .clock(link_clk),
        .rst_n(lrst_s2_r),
        .pin(scl_in),
        .filt(scl_f)
    );

    tws_glitch_filt u_sda_filt (
        .clock(link_clk),
        .rst_n(lrst_s2_r),
        .pin(sda_in),
        .filt(sda_f)
    );

    // Previous filtered levels for edge detection
    always_ff @(posedge link_clk) begin
        if (!lrst_s2_r) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_f;
            sda_d_r <= sda_f;
        end
    end

    logic scl_rise;       // Clock line rose
    logic scl_fall;       // Clock line fell
    logic start_w;        // Start or repeated start seen
    logic stop_w;         // Stop seen
    logic [6:0] my_addr;  // Strapped target address
    assign scl_rise = scl_f && !scl_d_r;
    assign scl_fall = !scl_f && scl_d_r;
    // R3: data falls while clock stays high
    assign start_w = scl_f && scl_d_r && !sda_f && sda_d_r;
    // R4: data rises while clock stays high
    assign stop_w = scl_f && scl_d_r && sda_f && !sda_d_r;
    // R12: fixed top bits, then offset and frequency straps
    assign my_addr = {TWS_ADDR_HI, strap_s2_r};

    // ****************************************************************
    // Link state machine
    // ****************************************************************
    tws_state_t st_r, st_nxt;            // Link state
    logic [3:0] bitcnt_r, bitcnt_nxt;    // Bits shifted in the current byte
    logic [7:0] shift_r, shift_nxt;      // Receive shift register
    logic [7:0] tx_r, tx_nxt;            // Transmit shift register
    logic sda_oe_r, sda_oe_nxt;          // Pull data line low
    logic rd_r, rd_nxt;                  // Current transfer is a read
    logic rd_idx_r, rd_idx_nxt;          // Second read byte already loaded
    logic rd_req_r, rd_req_nxt;          // Ask the system side for a snapshot
    logic wr_first_r, wr_first_nxt;      // Next written byte is the selector
    logic [1:0] ptr_r, ptr_nxt;          // Configuration byte written next
    logic wr_tog_r, wr_tog_nxt;          // Flips once per stored byte
    logic [7:0] cfg_q_r [TWS_CFG_BYTES]; // Link-side copy of the configuration
    logic [7:0] cfg_q_nxt [TWS_CFG_BYTES];
    logic [7:0] snap_stat_r;             // Status snapshot, system domain
    logic [7:0] snap_ampl_r;             // Amplitude snapshot, system domain

    // Next-state logic for the whole link side
    always_comb begin
        st_nxt = st_r;
        bitcnt_nxt = bitcnt_r;
        shift_nxt = shift_r;
        tx_nxt = tx_r;
        sda_oe_nxt = sda_oe_r;
        rd_nxt = rd_r;
        rd_idx_nxt = rd_idx_r;
        rd_req_nxt = rd_req_r;
        wr_first_nxt = wr_first_r;
        ptr_nxt = ptr_r;
        wr_tog_nxt = wr_tog_r;
        cfg_q_nxt = cfg_q_r;
        if (start_w) begin
            // R3: restart byte reception from the address
            st_nxt = TWS_ST_ADDR;
            bitcnt_nxt = 4'h0;
            sda_oe_nxt = 1'b0;
            rd_req_nxt = 1'b0;
        end else if (stop_w) begin
            // R4: end the transfer and let go of the line
            st_nxt = TWS_ST_IDLE;
            sda_oe_nxt = 1'b0;
            rd_req_nxt = 1'b0;
        end else begin
            case (st_r)
                TWS_ST_ADDR, TWS_ST_WRX: begin
                    // R7 R9: rising clock, MSB first
                    if (scl_rise && bitcnt_r != TWS_BYTE_BITS) begin
                        shift_nxt = {shift_r[6:0], sda_f};
                        bitcnt_nxt = bitcnt_r + 4'h1;
                    end else if (scl_fall && bitcnt_r == TWS_BYTE_BITS) begin
                        if (st_r == TWS_ST_ADDR) begin
                            // R13: strapped or general call address
                            if (shift_r[7:1] == my_addr || shift_r[7:1] == TWS_GCALL_ADDR) begin
                                // R16: low bit picks the direction
                                rd_nxt = (shift_r[0] == TWS_DIR_READ);
                                rd_req_nxt = (shift_r[0] == TWS_DIR_READ);
                                wr_first_nxt = 1'b1;
                                rd_idx_nxt = 1'b0;
                                // R15: acknowledge by pulling data low
                                sda_oe_nxt = 1'b1;
                                st_nxt = TWS_ST_AACK;
                            end else begin
                                // Not ours; wait quietly for the next start
                                st_nxt = TWS_ST_IDLE;
                            end
                        end else begin
                            if (wr_first_r) begin
                                // R23: selector picks the first target byte
                                ptr_nxt = shift_r[1:0];
                                wr_first_nxt = 1'b0;
                            end else begin
                                // R17: store payload, then step the pointer
                                cfg_q_nxt[ptr_r] = shift_r;
                                ptr_nxt = ptr_r + 2'h1;
                                wr_tog_nxt = !wr_tog_r;
                            end
                            // R11: the device receives, so it acknowledges
                            sda_oe_nxt = 1'b1;
                            st_nxt = TWS_ST_WACK;
                        end
                    end
                end
                TWS_ST_AACK, TWS_ST_WACK: begin
                    // R8: release only after the clock has fallen
                    if (scl_fall) begin
                        bitcnt_nxt = 4'h0;
                        if (st_r == TWS_ST_AACK && rd_r) begin
                            // R22: status byte goes first
                            tx_nxt = snap_stat_r;
                            // R24: only pull low for a zero bit
                            sda_oe_nxt = !snap_stat_r[7];
                            st_nxt = TWS_ST_RTX;
                        end else begin
                            sda_oe_nxt = 1'b0;
                            st_nxt = TWS_ST_WRX;
                        end
                    end
                end
                TWS_ST_RTX: begin
                    // R19: next bit goes out while the clock is low
                    if (scl_fall) begin
                        if (bitcnt_r == TWS_LAST_BIT) begin
                            sda_oe_nxt = 1'b0;
                            st_nxt = TWS_ST_RACK;
                        end else begin
                            tx_nxt = {tx_r[6:0], 1'b0};
                            sda_oe_nxt = !tx_r[6];
                            bitcnt_nxt = bitcnt_r + 4'h1;
                        end
                    end
                end
                TWS_ST_RACK: begin
                    if (scl_rise && sda_f) begin
                        // R21: no acknowledge ends the read
                        st_nxt = TWS_ST_IDLE;
                        rd_req_nxt = 1'b0;
                    end else if (scl_fall) begin
                        // R20: acknowledged, so send the next byte
                        bitcnt_nxt = 4'h0;
                        tx_nxt = rd_idx_r ? TWS_RD_FILL : snap_ampl_r;
                        sda_oe_nxt = rd_idx_r ? 1'b0 : !snap_ampl_r[7];
                        rd_idx_nxt = 1'b1;
                        st_nxt = TWS_ST_RTX;
                    end
                end
                TWS_ST_IDLE: begin
                    // R1: keep the line released between transfers
                    sda_oe_nxt = 1'b0;
                end
                default: begin
                    st_nxt = TWS_ST_IDLE;
                    sda_oe_nxt = 1'b0;
                end
            endcase
        end
    end

    // Register the link side
    always_ff @(posedge link_clk) begin
        if (!lrst_s2_r) begin
            st_r <= TWS_ST_IDLE;
            bitcnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            sda_oe_r <= 1'b0;
            rd_r <= 1'b0;
            rd_idx_r <= 1'b0;
            rd_req_r <= 1'b0;
            wr_first_r <= 1'b0;
            ptr_r <= TWS_PTR_W_ZERO;
            wr_tog_r <= 1'b0;
            for (int i = 0; i < TWS_CFG_BYTES; i++) begin
                cfg_q_r[i] <= TWS_CFG_RESET;
            end
        end else begin
            st_r <= st_nxt;
            bitcnt_r <= bitcnt_nxt;
            shift_r <= shift_nxt;
            tx_r <= tx_nxt;
            sda_oe_r <= sda_oe_nxt;
            rd_r <= rd_nxt;
            rd_idx_r <= rd_idx_nxt;
            rd_req_r <= rd_req_nxt;
            wr_first_r <= wr_first_nxt;
            ptr_r <= ptr_nxt;
            wr_tog_r <= wr_tog_nxt;
            cfg_q_r <= cfg_q_nxt;
        end
    end

    // R24: open drain; the driven value is always low
    always_ff @(posedge link_clk) begin
        sda_out <= 1'b0;
    end
    assign sda_oe = sda_oe_r;

    // ****************************************************************
    // System side: configuration capture and read snapshot
    // ****************************************************************
    logic wt_s1_r, wt_s2_r, wt_s3_r;     // Write toggle synchroniser and history
    logic rq_s1_r, rq_s2_r;              // Read request synchroniser
    logic [7:0] cfg_r [TWS_CFG_BYTES];   // Configuration seen by the system
    logic [7:0] cfg_nxt [TWS_CFG_BYTES];
    logic cfg_update_r, cfg_update_nxt;  // One-cycle pulse per stored byte
    logic snap_ok_r, snap_ok_nxt;        // Snapshot taken for this read
    logic [7:0] snap_stat_nxt, snap_ampl_nxt;

    // The link copy holds still for many microseconds after each toggle,
    // so it is safe to take whole once the toggle is seen here
    always_comb begin
        cfg_nxt = cfg_r;
        cfg_update_nxt = 1'b0;
        snap_ok_nxt = rq_s2_r;
        snap_stat_nxt = snap_stat_r;
        snap_ampl_nxt = snap_ampl_r;
        if (wt_s2_r != wt_s3_r) begin
            cfg_nxt = cfg_q_r;
            cfg_update_nxt = 1'b1;
        end
        // Freeze the snapshot for the whole read; the link reads it after
        // the address acknowledge, long after the request has crossed
        if (rq_s2_r && !snap_ok_r) begin
            snap_stat_nxt = {TWS_STAT_PAD, status_flags};
            snap_ampl_nxt = ampl_value;
        end
    end

    // Register the system side
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wt_s1_r <= 1'b0;
            wt_s2_r <= 1'b0;
            wt_s3_r <= 1'b0;
            rq_s1_r <= 1'b0;
            rq_s2_r <= 1'b0;
            for (int i = 0; i < TWS_CFG_BYTES; i++) begin
                cfg_r[i] <= TWS_CFG_RESET;
            end
            cfg_update_r <= 1'b0;
            snap_ok_r <= 1'b0;
            snap_stat_r <= 8'h00;
            snap_ampl_r <= 8'h00;
        end else begin
            wt_s1_r <= wr_tog_r;
            wt_s2_r <= wt_s1_r;
            wt_s3_r <= wt_s2_r;
            rq_s1_r <= rd_req_r;
            rq_s2_r <= rq_s1_r;
            cfg_r <= cfg_nxt;
            cfg_update_r <= cfg_update_nxt;
            snap_ok_r <= snap_ok_nxt;
            snap_stat_r <= snap_stat_nxt;
            snap_ampl_r <= snap_ampl_nxt;
        end
    end

    assign cfg_byte0 = cfg_r[0];
    assign cfg_byte1 = cfg_r[1];
    assign cfg_byte2 = cfg_r[2];
    assign cfg_byte3 = cfg_r[3];
    assign cfg_update = cfg_update_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    idle_release_a: assert property (@(posedge link_clk) disable iff (!lrst_s2_r) // R1
        st_r == TWS_ST_IDLE |-> !sda_oe_r) else $error("data pulled low while idle");
    start_restart_a: assert property (@(posedge link_clk) disable iff (!lrst_s2_r) // R3
        start_w |=> st_r == TWS_ST_ADDR && bitcnt_r == 4'h0) else $error("start missed");
    stop_end_a: assert property (@(posedge link_clk) disable iff (!lrst_s2_r) // R4
        stop_w && !start_w |=> st_r == TWS_ST_IDLE && !sda_oe_r) else $error("stop missed");
    rise_sample_a: assert property (@(posedge link_clk) disable iff (!lrst_s2_r) // R7
        (st_r == TWS_ST_WRX) && scl_rise && bitcnt_r < 4'h8 && !start_w && !stop_w
        |=> shift_r[0] == $past(sda_f)) else $error("bit not taken on rise");
    drive_low_a: assert property (@(posedge link_clk) disable iff (!lrst_s2_r) // R8
        $changed(sda_oe_r) && !$past(stop_w) && !$past(start_w) |-> !scl_f)
        else $error("data changed while clock high");
    byte_len_a: assert property (@(posedge link_clk) disable iff (!lrst_s2_r) // R9
        st_r == TWS_ST_WACK && $past(st_r) == TWS_ST_WRX |-> $past(bitcnt_r) == 4'h8)
        else $error("byte not eight bits");
    ack_low_a: assert property (@(posedge link_clk) disable iff (!lrst_s2_r) // R15
        st_r == TWS_ST_WACK || st_r == TWS_ST_AACK |-> sda_oe_r)
        else $error("acknowledge not driven");
    addr_match_a: assert property (@(posedge link_clk) disable iff (!lrst_s2_r) // R12
        st_r == TWS_ST_AACK && $past(st_r) == TWS_ST_ADDR
        |-> $past(shift_r[7:1]) == my_addr || $past(shift_r[7:1]) == TWS_GCALL_ADDR)
        else $error("acknowledged a foreign address");
    nack_release_a: assert property (@(posedge link_clk) disable iff (!lrst_s2_r) // R21
        st_r == TWS_ST_RACK && scl_rise && sda_f && !start_w && !stop_w
        |=> st_r == TWS_ST_IDLE ##1 !sda_oe_r) else $error("read kept after no acknowledge");
    sel_ptr_a: assert property (@(posedge link_clk) disable iff (!lrst_s2_r) // R23
        st_r == TWS_ST_WACK && $past(st_r) == TWS_ST_WRX && $past(wr_first_r)
        |-> ptr_r == $past(shift_r[1:0])) else $error("selector not applied");

    wr_byte_c: cover property (@(posedge link_clk) disable iff (!lrst_s2_r)
        wr_tog_r != $past(wr_tog_r));
    rd_two_c: cover property (@(posedge link_clk) disable iff (!lrst_s2_r)
        rd_idx_r && st_r == TWS_ST_RACK);
    gcall_c: cover property (@(posedge link_clk) disable iff (!lrst_s2_r)
        st_r == TWS_ST_ADDR && bitcnt_r == 4'h8 && shift_r[7:1] == TWS_GCALL_ADDR);
    restart_c: cover property (@(posedge link_clk) disable iff (!lrst_s2_r)
        start_w && st_r != TWS_ST_IDLE);
endmodule

// [tb/tws_master.sv]
// Bus master model that owns the serial clock and pulls the data line
module tws_master (
    input wire logic clock,
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 100ps;
    logic spk = 1'b0; // Adds a 40 ns clock spike in the low phase of every bit
    // both lines idle released, the clock is ours alone
    initial {scl, sda_pull} = 2'b10;
    // Set both lines, then hold a 500 ns step, one of three in each bit, so the slave filter settles
    task automatic lines(input logic c, input logic p);
        scl = c;
        sda_pull = p;
        repeat (20) @(negedge clock);
    endtask
    // data falls while the clock is high, also as a repeated start
    task automatic start();
        lines(1'b0, 1'b0);
        lines(1'b1, 1'b0);
        lines(1'b1, 1'b1);
        lines(1'b0, 1'b1);
    endtask
    // data rises while the clock is high
    task automatic stop();
        lines(1'b0, 1'b1);
        lines(1'b1, 1'b1);
        lines(1'b1, 1'b0);
    endtask
    // data moves in the low phase and is taken at the clock rise
    task automatic bit_io(input logic b, output logic r);
        lines(1'b0, !b);
        scl = spk;
        #40 scl = 1'b0;
        #100 r = sda;
        lines(1'b1, !b);
        lines(1'b0, !b);
    endtask
    // eight bits MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] w, input logic ak, output logic [7:0] rd,
        output logic a);
        for (int i = 7; i >= 0; i--) bit_io(w[i], rd[i]);
        bit_io(ak, a);
    endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the two-wire serial slave port
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0, link_clk = 1'b0, rst_n = 1'b0, scl, m_pull, sda_oe, sda_out, upd, ak;
    logic offs_strap = 1'b1;
    logic [2:0] fs = 3'h5; // Straps give address byte 9a for writes
    logic [3:0] flags = 4'h9;
    logic [7:0] ampl = 8'hc3, rd;
    logic [7:0] cfg [4];
    int err_count = 0, num_checks = 0, upd_n = 0;
    // pull-up unless a party pulls low; the device drives sda_out only when enabled
    wire logic sda = !(m_pull || (sda_oe && !sda_out));
    tws_slave uut (.clock(clock), .rst_n(rst_n), .link_clk(link_clk), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .offs_strap(offs_strap),
        .frequency_strap_pins(fs), .status_flags(flags), .ampl_value(ampl),
        .cfg_byte0(cfg[0]), .cfg_byte1(cfg[1]), .cfg_byte2(cfg[2]), .cfg_byte3(cfg[3]),
        .cfg_update(upd));
    tws_master m (.clock(clock), .sda(sda), .scl(scl), .sda_pull(m_pull));
    initial forever #12.5 clock = !clock;
    initial #7 forever #24 link_clk = !link_clk;
    always @(posedge clock) if (upd === 1'b1) upd_n <= upd_n + 1;
    // One comparison, counted and reported at once on mismatch
    task automatic compare(input logic [7:0] got, input logic [7:0] exp, input string s);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h want %h", $time, s, got, exp);
        end
    endtask
    // Written byte with the master released in the acknowledge slot
    task automatic wb(input logic [7:0] b, input logic want);
        m.xfer(b, 1'b1, rd, ak);
        compare({7'h0, ak}, {7'h0, want}, "ack bit");
    endtask
    task automatic t_write();
        int n0 = upd_n;
        m.start();
        wb(8'h9a, 1'b0);
        wb(8'h00, 1'b0);
        for (int i = 1; i < 5; i++) wb({4'(i), 4'hc}, 1'b0);
        m.stop();
        for (int i = 0; i < 4; i++) compare(cfg[i], {4'(i + 1), 4'hc}, "cfg");
        compare(8'(upd_n - n0), 8'h04, "update count");
        $display("t_write done");
    endtask
    // Spikes on the clock must not add bits to a general call write
    task automatic t_wrap();
        m.spk = 1'b1;
        m.start();
        wb(8'h00, 1'b0);
        wb(8'h03, 1'b0);
        wb(8'h5a, 1'b0);
        wb(8'h69, 1'b0);
        m.stop();
        m.spk = 1'b0;
        compare(cfg[3], 8'h5a, "cfg3");
        compare(cfg[0], 8'h69, "cfg0 after wrap");
        $display("t_wrap done");
    endtask
    task automatic t_addr();
        m.start();
        wb(8'h8a, 1'b1);
        m.start();
        wb(8'h9a, 1'b0);
        wb(8'h02, 1'b0);
        wb(8'h77, 1'b0);
        m.stop();
        compare(cfg[2], 8'h77, "cfg2");
        $display("t_addr done");
    endtask
    task automatic t_read();
        m.start();
        wb(8'h9b, 1'b0);
        m.xfer(8'hff, 1'b0, rd, ak);
        compare(rd, 8'h09, "status");
        m.xfer(8'hff, 1'b0, rd, ak);
        compare(rd, 8'hc3, "amplitude");
        m.xfer(8'hff, 1'b1, rd, ak);
        compare(rd, 8'hff, "fill byte");
        m.stop();
        compare({7'h0, sda_oe}, 8'h00, "released");
        $display("t_read done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Reset spans 6 cycles, enough for the link-side reset synchroniser
    initial begin
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        repeat (20) @(negedge clock);
        t_write();
        t_wrap();
        t_addr();
        t_read();
        report_and_stop();
    end
    // Watchdog, about seven times the expected run
    initial begin
        #2000000;
        err_count++;
        report_and_stop();
    end
endmodule
